// File: src/tsense_pkg.sv
// Purpose: Constants for the dual channel temperature conversion control block
// Assumes: 100 MHz SYS_CLK, classic Wishbone register access, 32-bit data
// Notes:   Registers are one aligned word each, data in the low byte
package tsense_pkg;
    // ****************************************
    // Register byte offsets
    // ****************************************
    localparam logic [7:0] OFS_REMOTE    = 8'h00;
    localparam logic [7:0] OFS_LOCAL     = 8'h04;
    localparam logic [7:0] OFS_CONFIG    = 8'h08;
    localparam logic [7:0] OFS_STATUS    = 8'h0c;
    localparam logic [7:0] OFS_MASK      = 8'h10;
    localparam logic [7:0] OFS_RATE      = 8'h14;
    localparam logic [7:0] OFS_ONESHOT   = 8'h18;
    localparam logic [7:0] OFS_REM_HIGH  = 8'h1c;
    localparam logic [7:0] OFS_REM_LOW   = 8'h20;
    localparam logic [7:0] OFS_LOC_HIGH  = 8'h24;
    localparam logic [7:0] OFS_LOC_LOW   = 8'h28;
    localparam logic [7:0] OFS_ADDR      = 8'h2c;
    localparam logic [7:0] OFS_SHIFT     = 8'h30;
    // ****************************************
    // Field positions
    // ****************************************
    localparam int CFG_RUN_STOP_BIT = 6;
    localparam int ST_LOC_HIGH_BIT  = 0;
    localparam int ST_LOC_LOW_BIT   = 1;
    localparam int ST_REM_HIGH_BIT  = 2;
    localparam int ST_REM_LOW_BIT   = 3;
    localparam int ST_DONE_BIT      = 4;
    localparam int ST_BUSY_BIT      = 7;
    localparam logic [4:0] ST_STICKY_MASK = 5'h1f;
    // ****************************************
    // Reset values
    // ****************************************
    localparam logic [7:0] RST_RESULT   = 8'h00;
    localparam logic [7:0] RST_CONFIG   = 8'h00;
    localparam logic [7:0] RST_MASK     = 8'h00;
    localparam logic [7:0] RST_RATE     = 8'h02;
    localparam logic [7:0] RST_HIGH     = 8'h7f;
    localparam logic [7:0] RST_LOW      = 8'hc9;
    localparam logic [6:0] ADDR_BASE    = 7'h18;
    // ****************************************
    // Timing
    // ****************************************
    localparam int CLK_HZ          = 100_000_000;
    localparam int WINDOW_MS       = 60;
    localparam int WINDOW_CYCLES   = int'((64'(CLK_HZ) * 64'(WINDOW_MS)) / 64'd1000);
    localparam int RATE_UNIT_MS    = 250;
    localparam int RATE_UNIT_CYCLES = int'((64'(CLK_HZ) * 64'(RATE_UNIT_MS)) / 64'd1000);
endpackage

// File: src/temp_conv_ctrl.sv
// Purpose: Conversion sequencer, result and threshold registers, alert for a two channel sensor
// Assumes: Analog measurement arrives as signed bytes; pins cross in through two flip-flops
// Notes:   Serial transaction decoding lives elsewhere; only the pins and a byte shifted out on the data pin are kept here
//
// The Wishbone interface to the registers and the address map were left to the implementer.
`timescale 1ns/10ps
`default_nettype none
module temp_conv_ctrl #(
    parameter int WINDOW_CYCLES    = tsense_pkg::WINDOW_CYCLES,
    parameter int RATE_UNIT_CYCLES = tsense_pkg::RATE_UNIT_CYCLES
) (
    input  wire logic        SYS_CLK,
    input  wire logic        RESET_N,
    input  wire logic        CLK_EN,
    input  wire logic        WB_CYC_I,
    input  wire logic        WB_STB_I,
    input  wire logic        WB_WE_I,
    input  wire logic [7:0]  WB_ADR_I,
    input  wire logic [3:0]  WB_SEL_I,
    input  wire logic [31:0] WB_DAT_I,
    output logic      [31:0] WB_DAT_O,
    output logic             WB_ACK_O,
    input  wire logic [7:0]  REMOTE_SAMPLE,
    input  wire logic [7:0]  LOCAL_SAMPLE,
    output logic             CHANNEL_SEL,
    input  wire logic        HW_STANDBY_N,
    input  wire logic        ADDR_SELECT_LO,
    input  wire logic        ADDR_SELECT_HI,
    output logic      [6:0]  SLAVE_ADDR,
    input  wire logic        SER_CLK_I,
    input  wire logic        SER_DATA_I,
    output logic             SER_DATA_O,
    output logic             SER_DATA_OE,
    output logic             ALERT_O,
    output logic             ALERT_OE,
    output logic             IRQ
);
    typedef enum logic [1:0] {IDLE, CONV_REMOTE, CONV_LOCAL} conv_state_e;

    // ****************************************
    // Pin synchronisers
    // ****************************************
    logic [4:0] pin_meta_reg;
    logic [4:0] pin_sync_reg;
    // Reset to idle pin levels, so no false serial clock edge follows reset
    always_ff @(posedge SYS_CLK) begin
        if (!RESET_N) begin
            pin_meta_reg <= 5'h19;
            pin_sync_reg <= 5'h19;
        end else if (CLK_EN) begin
            pin_meta_reg <= {SER_DATA_I, SER_CLK_I, ADDR_SELECT_HI, ADDR_SELECT_LO, HW_STANDBY_N};
            pin_sync_reg <= pin_meta_reg;
        end
    end
    logic hw_standby_n;
    assign hw_standby_n = pin_sync_reg[0];

    // Straps caught once, after the synchroniser has filled
    logic [1:0] strap_cnt_reg;
    logic [1:0] addr_strap_reg;
    always_ff @(posedge SYS_CLK) begin
        if (!RESET_N) begin
            strap_cnt_reg  <= 2'h0;
            addr_strap_reg <= 2'h0;
        end else if (CLK_EN) begin
            if (strap_cnt_reg != 2'h3) begin
                strap_cnt_reg <= strap_cnt_reg + 2'h1;
                if (strap_cnt_reg == 2'h2) begin
                    addr_strap_reg <= pin_sync_reg[2:1];
                end
            end
        end
    end
    assign SLAVE_ADDR = {tsense_pkg::ADDR_BASE[6:2], addr_strap_reg};

    // ****************************************
    // Register bus decode
    // ****************************************
    logic       wb_req;
    logic       wb_wr;
    logic       ack_reg;
    assign wb_req   = WB_CYC_I && WB_STB_I && !ack_reg;
    assign wb_wr    = wb_req && WB_WE_I && WB_SEL_I[0];
    assign WB_ACK_O = ack_reg;

    logic [7:0] remote_reg;
    logic [7:0] local_reg;
    logic [7:0] config_reg;
    logic [7:0] mask_reg;
    logic [7:0] rate_reg;
    logic [7:0] rem_high_reg;
    logic [7:0] rem_low_reg;
    logic [7:0] loc_high_reg;
    logic [7:0] loc_low_reg;
    logic [4:0] status_reg;
    logic [7:0] shift_reg;
    logic       oneshot_req;
    logic       sw_standby;
    assign oneshot_req = wb_wr && (WB_ADR_I == tsense_pkg::OFS_ONESHOT);
    assign sw_standby  = config_reg[tsense_pkg::CFG_RUN_STOP_BIT];

    // Thresholds and configuration are written only by software, so standby keeps them
    always_ff @(posedge SYS_CLK) begin
        if (!RESET_N) begin
            config_reg   <= tsense_pkg::RST_CONFIG;
            mask_reg     <= tsense_pkg::RST_MASK;
            rate_reg     <= tsense_pkg::RST_RATE;
            rem_high_reg <= tsense_pkg::RST_HIGH;
            rem_low_reg  <= tsense_pkg::RST_LOW;
            loc_high_reg <= tsense_pkg::RST_HIGH;
            loc_low_reg  <= tsense_pkg::RST_LOW;
        end else if (CLK_EN && wb_wr) begin
            case (WB_ADR_I)
                tsense_pkg::OFS_CONFIG:   config_reg   <= WB_DAT_I[7:0];
                tsense_pkg::OFS_MASK:     mask_reg     <= WB_DAT_I[7:0];
                tsense_pkg::OFS_RATE:     rate_reg     <= WB_DAT_I[7:0];
                tsense_pkg::OFS_REM_HIGH: rem_high_reg <= WB_DAT_I[7:0];
                tsense_pkg::OFS_REM_LOW:  rem_low_reg  <= WB_DAT_I[7:0];
                tsense_pkg::OFS_LOC_HIGH: loc_high_reg <= WB_DAT_I[7:0];
                tsense_pkg::OFS_LOC_LOW:  loc_low_reg  <= WB_DAT_I[7:0];
                default: ;
            endcase
        end
    end

    // ****************************************
    // Conversion sequencer
    // ****************************************
    conv_state_e state_reg;
    logic [31:0] win_cnt_reg;
    logic [31:0] rate_cnt_reg;
    logic [7:0]  rate_ticks_reg;
    logic [7:0]  rem_part_reg;
    logic        busy;
    logic        standby_any;
    logic        auto_start;
    logic        start;
    logic        win_done;
    logic        conv_done;
    assign busy        = (state_reg != IDLE);
    assign standby_any = !hw_standby_n || sw_standby;
    // Free-running timer only runs outside standby; a one shot passes software standby only
    assign start       = !busy && hw_standby_n && (oneshot_req || (auto_start && !sw_standby));
    assign win_done    = (win_cnt_reg == 32'(WINDOW_CYCLES - 1));
    assign conv_done   = (state_reg == CONV_LOCAL) && win_done;
    assign CHANNEL_SEL = (state_reg == CONV_LOCAL);

    // ****************************************
    // Standby abort
    // ****************************************
    // A one shot may start in software standby, so only a software standby
    // that arrives after the start cuts the conversion short
    logic sw_ok_reg;
    logic abort;
    always_ff @(posedge SYS_CLK) begin
        if (!RESET_N) begin
            sw_ok_reg <= 1'b0;
        end else if (CLK_EN) begin
            if (start) begin
                sw_ok_reg <= sw_standby;
            end else if (!sw_standby) begin
                sw_ok_reg <= 1'b0;
            end
        end
    end
    assign abort = !hw_standby_n || (sw_standby && !sw_ok_reg);

    // Period is rate_reg units after the previous start; zero means back to back
    always_ff @(posedge SYS_CLK) begin
        if (!RESET_N) begin
            rate_cnt_reg   <= 32'h0;
            rate_ticks_reg <= 8'h00;
        end else if (CLK_EN) begin
            if (standby_any || start) begin
                rate_cnt_reg   <= 32'h0;
                rate_ticks_reg <= 8'h00;
            end else if (rate_cnt_reg == 32'(RATE_UNIT_CYCLES - 1)) begin
                rate_cnt_reg <= 32'h0;
                if (rate_ticks_reg != 8'hff) begin
                    rate_ticks_reg <= rate_ticks_reg + 8'h01;
                end
            end else begin
                rate_cnt_reg <= rate_cnt_reg + 32'h1;
            end
        end
    end
    assign auto_start = (rate_ticks_reg >= rate_reg);

    always_ff @(posedge SYS_CLK) begin
        if (!RESET_N) begin
            state_reg    <= IDLE;
            win_cnt_reg  <= 32'h0;
            rem_part_reg <= 8'h00;
        end else if (CLK_EN) begin
            case (state_reg)
                IDLE: begin
                    win_cnt_reg <= 32'h0;
                    if (start) begin
                        state_reg <= CONV_REMOTE;
                    end
                end
                CONV_REMOTE: begin
                    if (abort) begin
                        state_reg <= IDLE;
                    end else if (win_done) begin
                        win_cnt_reg  <= 32'h0;
                        rem_part_reg <= REMOTE_SAMPLE;
                        state_reg    <= CONV_LOCAL;
                    end else begin
                        win_cnt_reg <= win_cnt_reg + 32'h1;
                    end
                end
                CONV_LOCAL: begin
                    if (abort) begin
                        state_reg <= IDLE;
                    end else if (win_done) begin
                        win_cnt_reg <= 32'h0;
                        state_reg   <= IDLE;
                    end else begin
                        win_cnt_reg <= win_cnt_reg + 32'h1;
                    end
                end
                default: state_reg <= IDLE;
            endcase
        end
    end

    // Abort skips this load, so a partial remote value is never seen
    logic commit;
    assign commit = conv_done && !abort;
    always_ff @(posedge SYS_CLK) begin
        if (!RESET_N) begin
            remote_reg <= tsense_pkg::RST_RESULT;
            local_reg  <= tsense_pkg::RST_RESULT;
        end else if (CLK_EN && commit) begin
            remote_reg <= rem_part_reg;
            local_reg  <= LOCAL_SAMPLE;
        end
    end

    // ****************************************
    // Threshold compare and status
    // ****************************************
    // Channel 0 is local and channel 1 remote, matching the status bit pairs
    // Compares use the values being committed, never the previous results
    logic [7:0] cmp_value [2];
    logic [7:0] cmp_high  [2];
    logic [7:0] cmp_low   [2];
    assign cmp_value[0] = LOCAL_SAMPLE;
    assign cmp_value[1] = rem_part_reg;
    assign cmp_high[0]  = loc_high_reg;
    assign cmp_high[1]  = rem_high_reg;
    assign cmp_low[0]   = loc_low_reg;
    assign cmp_low[1]   = rem_low_reg;
    logic [4:0] events;
    for (genvar ch = 0; ch < 2; ch++) begin : g_cmp
        assign events[tsense_pkg::ST_LOC_HIGH_BIT + 2 * ch] = commit && ($signed(cmp_value[ch]) > $signed(cmp_high[ch]));
        assign events[tsense_pkg::ST_LOC_LOW_BIT + 2 * ch]  = commit && ($signed(cmp_value[ch]) < $signed(cmp_low[ch]));
    end
    assign events[tsense_pkg::ST_DONE_BIT] = commit;

    logic [4:0] clr_bits;
    assign clr_bits = (wb_wr && (WB_ADR_I == tsense_pkg::OFS_STATUS)) ? WB_DAT_I[4:0] : 5'h00;

    // Set wins over a write-one clear in the same cycle
    always_ff @(posedge SYS_CLK) begin
        if (!RESET_N) begin
            status_reg <= 5'h00;
        end else if (CLK_EN) begin
            status_reg <= ((status_reg & ~clr_bits) | events) & tsense_pkg::ST_STICKY_MASK;
        end
    end

    logic alert_reg;
    always_ff @(posedge SYS_CLK) begin
        if (!RESET_N) begin
            alert_reg <= 1'b0;
        end else if (CLK_EN) begin
            alert_reg <= |(status_reg & mask_reg[4:0]);
        end
    end
    assign IRQ      = alert_reg;
    assign ALERT_O  = 1'b0;
    assign ALERT_OE = alert_reg;

    // ****************************************
    // Serial data pin, open drain
    // ****************************************
    // Software loads a byte at OFS_SHIFT; it is pushed MSB first on falling serial clock edges
    logic ser_clk_d_reg;
    always_ff @(posedge SYS_CLK) begin
        if (!RESET_N) begin
            shift_reg     <= 8'hff;
            ser_clk_d_reg <= 1'b1;
        end else if (CLK_EN) begin
            ser_clk_d_reg <= pin_sync_reg[3];
            if (wb_wr && (WB_ADR_I == tsense_pkg::OFS_SHIFT)) begin
                shift_reg <= WB_DAT_I[7:0];
            end else if (ser_clk_d_reg && !pin_sync_reg[3]) begin
                shift_reg <= {shift_reg[6:0], 1'b1};
            end
        end
    end
    assign SER_DATA_O  = 1'b0;
    assign SER_DATA_OE = !shift_reg[7];

    // ****************************************
    // Read mux and acknowledge
    // ****************************************
    logic [7:0] rd_byte;
    always_comb begin
        case (WB_ADR_I)
            tsense_pkg::OFS_REMOTE:   rd_byte = remote_reg;
            tsense_pkg::OFS_LOCAL:    rd_byte = local_reg;
            tsense_pkg::OFS_CONFIG:   rd_byte = config_reg;
            tsense_pkg::OFS_STATUS:   rd_byte = {busy, 2'b00, status_reg};
            tsense_pkg::OFS_MASK:     rd_byte = mask_reg;
            tsense_pkg::OFS_RATE:     rd_byte = rate_reg;
            tsense_pkg::OFS_REM_HIGH: rd_byte = rem_high_reg;
            tsense_pkg::OFS_REM_LOW:  rd_byte = rem_low_reg;
            tsense_pkg::OFS_LOC_HIGH: rd_byte = loc_high_reg;
            tsense_pkg::OFS_LOC_LOW:  rd_byte = loc_low_reg;
            tsense_pkg::OFS_ADDR:     rd_byte = {1'b0, SLAVE_ADDR};
            tsense_pkg::OFS_SHIFT:    rd_byte = {pin_sync_reg[4], 6'h00, hw_standby_n};
            // Unmapped offsets read as zero and are still acknowledged
            default:                  rd_byte = 8'h00;
        endcase
    end

    // Every request is answered on the next edge; there are no wait states
    always_ff @(posedge SYS_CLK) begin
        if (!RESET_N) begin
            ack_reg  <= 1'b0;
            WB_DAT_O <= 32'h0;
        end else if (CLK_EN) begin
            ack_reg <= wb_req;
            if (wb_req) begin
                WB_DAT_O <= {24'h000000, rd_byte};
            end
        end
    end
endmodule
`default_nettype wire

// File: sim/tcc_sva.sv
// Purpose: Port assertions for temp_conv_ctrl
// Assumes: One clock domain, CLK_EN high
// Notes:   Bound to every temp_conv_ctrl below the module
`timescale 1ns/10ps
`default_nettype none
module tcc_sva #(
    parameter int WINDOW_CYCLES = 20
) (
    input wire logic        SYS_CLK,
    input wire logic        RESET_N,
    input wire logic        CLK_EN,
    input wire logic        WB_CYC_I,
    input wire logic        WB_STB_I,
    input wire logic [31:0] WB_DAT_O,
    input wire logic        WB_ACK_O,
    input wire logic        CHANNEL_SEL,
    input wire logic        HW_STANDBY_N,
    input wire logic [6:0]  SLAVE_ADDR,
    input wire logic        SER_DATA_O,
    input wire logic        SER_DATA_OE,
    input wire logic        ALERT_O,
    input wire logic        ALERT_OE,
    input wire logic        IRQ
);
    logic [31:0] sel_run;
    logic [2:0]  since_rst;
    default clocking dclk @(posedge SYS_CLK); endclocking
    default disable iff (!RESET_N);
    // ****
    // Helpers: an abort may shorten a window, never stretch it
    // ****
    always_ff @(posedge SYS_CLK) begin
        if (!RESET_N || !CHANNEL_SEL) begin
            sel_run <= 32'h0;
        end else if (CLK_EN) begin
            sel_run <= sel_run + 32'h1;
        end
    end
    always_ff @(posedge SYS_CLK) begin
        if (!RESET_N) begin
            since_rst <= 3'h0;
        end else if (CLK_EN && since_rst != 3'h7) begin
            since_rst <= since_rst + 3'h1;
        end
    end
    property p_alert_od; !ALERT_O; endproperty
    a_alert_od: assert property (p_alert_od) else $error("alert pin driven high");
    property p_data_od; !SER_DATA_O; endproperty
    a_data_od: assert property (p_data_od) else $error("data pin driven high");
    property p_irq_alert; IRQ == ALERT_OE; endproperty
    a_irq_alert: assert property (p_irq_alert) else $error("irq and alert differ");
    property p_ack_pulse; WB_ACK_O && CLK_EN |=> !WB_ACK_O; endproperty
    a_ack_pulse: assert property (p_ack_pulse) else $error("ack longer than one cycle");
    property p_ack_answer; WB_CYC_I && WB_STB_I && !WB_ACK_O && CLK_EN |=> WB_ACK_O; endproperty
    a_ack_answer: assert property (p_ack_answer) else $error("request not acked");
    property p_dat_byte; WB_ACK_O |-> WB_DAT_O[31:8] == 24'h0; endproperty
    a_dat_byte: assert property (p_dat_byte) else $error("read data wider than a byte");
    property p_window; CHANNEL_SEL |-> sel_run < WINDOW_CYCLES; endproperty
    a_window: assert property (p_window) else $error("local window too long");
    property p_addr; since_rst >= 3'h5 |-> $stable(SLAVE_ADDR) && SLAVE_ADDR[6:2] == 5'h06; endproperty
    a_addr: assert property (p_addr) else $error("slave address moved");
    property p_standby; !HW_STANDBY_N [*6] |-> !CHANNEL_SEL; endproperty
    a_standby: assert property (p_standby) else $error("conversion in standby");
    property p_rst; disable iff (1'b0) !RESET_N |=> !WB_ACK_O && !IRQ && !SER_DATA_OE && !ALERT_OE; endproperty
    a_rst: assert property (p_rst) else $error("outputs active in reset");
endmodule
bind temp_conv_ctrl tcc_sva #(.WINDOW_CYCLES(WINDOW_CYCLES)) chk (
    .SYS_CLK(SYS_CLK), .RESET_N(RESET_N), .CLK_EN(CLK_EN), .WB_CYC_I(WB_CYC_I), .WB_STB_I(WB_STB_I),
    .WB_DAT_O(WB_DAT_O), .WB_ACK_O(WB_ACK_O), .CHANNEL_SEL(CHANNEL_SEL), .HW_STANDBY_N(HW_STANDBY_N),
    .SLAVE_ADDR(SLAVE_ADDR), .SER_DATA_O(SER_DATA_O), .SER_DATA_OE(SER_DATA_OE), .ALERT_O(ALERT_O),
    .ALERT_OE(ALERT_OE), .IRQ(IRQ));
`default_nettype wire

// File: sim/afe_model.sv
// Purpose: Analog front end stand-in feeding signed channel samples
// Assumes: Remote sampled while channel_sel is low, local while high
// Notes:   The idle channel shows the inverse so a late sample is caught
`timescale 1ns/10ps
`default_nettype none
module afe_model (
    input  wire logic       channel_sel,
    input  wire logic [7:0] rem_value,
    input  wire logic [7:0] loc_value,
    output logic      [7:0] remote_sample,
    output logic      [7:0] local_sample
);
    assign remote_sample = channel_sel ? ~rem_value : rem_value;
    assign local_sample  = channel_sel ? loc_value : ~loc_value;
endmodule
`default_nettype wire

// File: sim/test_dual_channel_temp_conversion_control.sv
// Purpose: Self-checking bench for temp_conv_ctrl
// Assumes: Window of 20 cycles and rate unit of 10 keep the run short
// Notes:   Thresholds and samples are random with a fixed seed
`timescale 1ns/10ps
`default_nettype none
module test_dual_channel_temp_conversion_control;
    localparam int WIN = 20;
    logic        clk = 1'b0, rst_n = 1'b0, cyc = 1'b0, stb = 1'b0, we = 1'b0;
    logic        hw_standby_n_n = 1'b1, a_lo = 1'b0, a_hi = 1'b0, scl = 1'b1;
    logic        ack, ch_sel, sda_o, sda_oe, al_o, al_oe, irq;
    logic [7:0]  adr = 8'h00, rem_v = 8'h00, loc_v = 8'h00, prev = 8'h00;
    logic [7:0]  rem_s, loc_s, r, l, rh, rl, lh, ll, f;
    logic [31:0] dat_i = 32'h0, dat_o, q;
    logic [6:0]  saddr;
    logic [7:0]  ofs [8] = '{tsense_pkg::OFS_REMOTE, tsense_pkg::OFS_LOCAL, tsense_pkg::OFS_MASK, tsense_pkg::OFS_RATE,
        tsense_pkg::OFS_REM_HIGH, tsense_pkg::OFS_REM_LOW, tsense_pkg::OFS_LOC_HIGH, tsense_pkg::OFS_LOC_LOW};
    logic [7:0]  rv [8] = '{8'h00, 8'h00, 8'h00, 8'h02, 8'h7f, 8'hc9, 8'h7f, 8'hc9};
    int          errors = 0;
    int          check_count = 0;
    always #5 clk = ~clk;
    temp_conv_ctrl #(.WINDOW_CYCLES(WIN), .RATE_UNIT_CYCLES(10)) uut (
        .SYS_CLK(clk), .RESET_N(rst_n), .CLK_EN(1'b1), .WB_CYC_I(cyc), .WB_STB_I(stb), .WB_WE_I(we),
        .WB_ADR_I(adr), .WB_SEL_I(4'h1), .WB_DAT_I(dat_i), .WB_DAT_O(dat_o), .WB_ACK_O(ack),
        .REMOTE_SAMPLE(rem_s), .LOCAL_SAMPLE(loc_s), .CHANNEL_SEL(ch_sel), .HW_STANDBY_N(hw_standby_n_n),
        .ADDR_SELECT_LO(a_lo), .ADDR_SELECT_HI(a_hi), .SLAVE_ADDR(saddr), .SER_CLK_I(scl),
        .SER_DATA_I(!sda_oe), .SER_DATA_O(sda_o), .SER_DATA_OE(sda_oe), .ALERT_O(al_o),
        .ALERT_OE(al_oe), .IRQ(irq));
    afe_model afe (.channel_sel(ch_sel), .rem_value(rem_v), .loc_value(loc_v),
                   .remote_sample(rem_s), .local_sample(loc_s));
    // ****
    // Bus cycle, compare and verdict
    // ****
    task automatic wb(input logic w, input logic [7:0] a, input logic [7:0] d);
        int n;
        n = 0;
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        dat_i <= {24'h0, d};
        do begin
            @(posedge clk);
            n++;
        end while (ack !== 1'b1 && n < 50);
        q = dat_o;
        if (n >= 50) errors++;
        cyc <= 1'b0;
        stb <= 1'b0;
        @(posedge clk);
    endtask
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        check_count++;
        if (got !== exp) begin
            errors++;
            $display("Error %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp, input string what);
        wb(1'b0, a, 8'h00);
        chk(what, exp, q);
    endtask
    // Polling is bounded; a stuck flag ends as a mismatch
    task automatic wait_bit(input int b, input logic v);
        int n;
        n = 0;
        do begin
            wb(1'b0, tsense_pkg::OFS_STATUS, 8'h00);
            n++;
        end while (q[b] !== v && n < 100);
        chk("status bit", 32'(v), 32'(q[b]));
    endtask
    function automatic logic [7:0] flags(input logic [7:0] x, input logic [7:0] y);
        flags = 8'h00;
        flags[tsense_pkg::ST_DONE_BIT] = 1'b1;
        flags[tsense_pkg::ST_REM_HIGH_BIT] = $signed(x) > $signed(rh);
        flags[tsense_pkg::ST_REM_LOW_BIT] = $signed(x) < $signed(rl);
        flags[tsense_pkg::ST_LOC_HIGH_BIT] = $signed(y) > $signed(lh);
        flags[tsense_pkg::ST_LOC_LOW_BIT] = $signed(y) < $signed(ll);
    endfunction
    task automatic report_and_stop;
        if (errors == 0 && check_count > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    initial begin
        #200000;
        errors++;
        report_and_stop();
    end
    initial begin
        void'($urandom(68325));
        a_lo = 1'($urandom);
        a_hi = 1'($urandom);
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        wb(1'b1, tsense_pkg::OFS_CONFIG, 8'h40);
        foreach (ofs[i]) rd_chk(ofs[i], {24'h0, rv[i]}, "reset value");
        rd_chk(tsense_pkg::OFS_ADDR, {25'h0, tsense_pkg::ADDR_BASE[6:2], a_hi, a_lo}, "slave addr");
        rd_chk(tsense_pkg::OFS_CONFIG, 32'h40, "config");
        wb(1'b1, 8'h3c, 8'hff);
        rd_chk(8'h3c, 32'h0, "unmapped");
        // Data pin reads back through its pull-up; one bit per falling serial clock
        f = 8'($urandom);
        wb(1'b1, tsense_pkg::OFS_SHIFT, f);
        for (int k = 7; k >= 0; k--) begin
            rd_chk(tsense_pkg::OFS_SHIFT, {24'h0, f[k], 7'h01}, "data pin");
            scl <= 1'b0;
            repeat (6) @(posedge clk);
            scl <= 1'b1;
        end
        rd_chk(tsense_pkg::OFS_SHIFT, 32'h81, "data pin released");
        for (int i = 0; i < 6; i++) begin
            {rh, rl, lh, ll} = $urandom;
            r = (i == 0) ? rh : (i == 1) ? 8'h80 : 8'($urandom);
            l = (i == 0) ? ll : (i == 1) ? 8'h7f : 8'($urandom);
            wb(1'b1, tsense_pkg::OFS_REM_HIGH, rh);
            wb(1'b1, tsense_pkg::OFS_REM_LOW, rl);
            wb(1'b1, tsense_pkg::OFS_LOC_HIGH, lh);
            wb(1'b1, tsense_pkg::OFS_LOC_LOW, ll);
            wb(1'b1, tsense_pkg::OFS_MASK, 8'h0f);
            wb(1'b1, tsense_pkg::OFS_STATUS, 8'h1f);
            rem_v <= r;
            loc_v <= l;
            wb(1'b1, tsense_pkg::OFS_ONESHOT, 8'h01);
            wait_bit(tsense_pkg::ST_BUSY_BIT, 1'b1);
            rd_chk(tsense_pkg::OFS_REMOTE, {24'h0, prev}, "remote while busy");
            wait_bit(tsense_pkg::ST_BUSY_BIT, 1'b0);
            rd_chk(tsense_pkg::OFS_REMOTE, {24'h0, r}, "remote");
            rd_chk(tsense_pkg::OFS_LOCAL, {24'h0, l}, "local");
            f = flags(r, l);
            rd_chk(tsense_pkg::OFS_STATUS, {24'h0, f}, "status");
            chk("irq", 32'(|f[3:0]), 32'(irq));
            wb(1'b1, tsense_pkg::OFS_STATUS, 8'h1f);
            chk("irq cleared", 32'h0, 32'(irq));
            prev = r;
        end
        rem_v <= ~r;
        loc_v <= ~l;
        wb(1'b1, tsense_pkg::OFS_ONESHOT, 8'h01);
        repeat (WIN + 8) @(posedge clk);
        hw_standby_n_n <= 1'b0;
        repeat (WIN) @(posedge clk);
        wb(1'b1, tsense_pkg::OFS_ONESHOT, 8'h01);
        repeat (3 * WIN) @(posedge clk);
        wb(1'b0, tsense_pkg::OFS_STATUS, 8'h00);
        chk("busy in standby", 32'h0, 32'(q[tsense_pkg::ST_BUSY_BIT]));
        rd_chk(tsense_pkg::OFS_REMOTE, {24'h0, r}, "remote kept");
        rd_chk(tsense_pkg::OFS_LOCAL, {24'h0, l}, "local kept");
        rd_chk(tsense_pkg::OFS_LOC_LOW, {24'h0, ll}, "threshold kept");
        // The synchronised pin is still low when this one shot is taken; a start
        // that slipped through would no longer be aborted and would show busy
        hw_standby_n_n <= 1'b1;
        @(posedge clk);
        wb(1'b1, tsense_pkg::OFS_ONESHOT, 8'h01);
        rd_chk(tsense_pkg::OFS_STATUS, 32'h0, "status after pin standby");
        wb(1'b1, tsense_pkg::OFS_STATUS, 8'h1f);
        wb(1'b1, tsense_pkg::OFS_RATE, 8'h01);
        wb(1'b1, tsense_pkg::OFS_CONFIG, 8'h00);
        wait_bit(tsense_pkg::ST_DONE_BIT, 1'b1);
        rd_chk(tsense_pkg::OFS_REMOTE, {24'h0, ~r}, "free run remote");
        rd_chk(tsense_pkg::OFS_LOCAL, {24'h0, ~l}, "free run local");
        wb(1'b1, tsense_pkg::OFS_CONFIG, 8'h40);
        report_and_stop();
    end
endmodule
`default_nettype wire
